// ### src/ctc_pkg.sv
// Package for the compact timer core: register map, field layouts, modes
package ctc_pkg;
  localparam int unsigned ADDR_W = 5;
  // Byte offsets of the registers
  localparam logic [4:0] OFF_PIN_FUNCTION_SELECT = 5'h00;
  localparam logic [4:0] OFF_TIMER_CONTROL_ZERO  = 5'h04;
  localparam logic [4:0] OFF_TIMER_CONTROL_ONE   = 5'h08;
  localparam logic [4:0] OFF_COUNTER_VALUE_LOW   = 5'h0c;
  localparam logic [4:0] OFF_COUNTER_VALUE_HIGH  = 5'h10;
  localparam logic [4:0] OFF_COMPARE_A_LOW       = 5'h14;
  localparam logic [4:0] OFF_COMPARE_A_HIGH      = 5'h18;
  // Pin function select field positions
  localparam int unsigned THIRD_TIMER_CLOCK_PIN_SEL   = 7;
  localparam int unsigned SECOND_TIMER_CLOCK_PIN_SEL  = 6;
  localparam int unsigned COMPACT_TIMER_CLOCK_PIN_SEL = 5;
  localparam int unsigned EXT_INTERRUPT_PIN_SEL       = 4;
  localparam int unsigned PORTD4_SPECIAL_SEL          = 0;
  // Reset values and counter constants
  localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h00;
  localparam logic [7:0] RST_CONTROL             = 8'h00;
  localparam logic [9:0] RST_COUNTER             = 10'h000;
  localparam logic [9:0] RST_COMPARE_A           = 10'h000;
  localparam logic [9:0] COUNTER_MAX             = 10'h3ff;
  localparam int unsigned PERIOD_SHIFT           = 7;
  localparam logic [1:0] SYS_DIV4_LAST           = 2'h3;
  // Counter clock sources
  localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CK_SYS      = 3'h1;
  localparam logic [2:0] CK_FH_DIV16 = 3'h2;
  localparam logic [2:0] CK_FH_DIV64 = 3'h3;
  localparam logic [2:0] CK_SUB      = 3'h4;
  localparam logic [2:0] CK_RESERVED = 3'h5;
  localparam logic [2:0] CK_PIN_RISE = 3'h6;
  localparam logic [2:0] CK_PIN_FALL = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF   = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } ctc_mode_type;

  typedef struct packed {
    logic       pause;
    logic [2:0] clk_sel;
    logic       timer_on_control;
    logic [2:0] period_compare_value;
  } ctc_ctl0_type;

  typedef struct packed {
    ctc_mode_type mode;
    logic [1:0]   out_func;
    logic         out_ctrl;
    logic         polarity;
    logic         duty_swap;
    logic         counter_clear_select;
  } ctc_ctl1_type;
endpackage : ctc_pkg

// ### src/ctc_timer.sv
// Compact 10-bit timer core with buffered byte access over AXI4-Lite
//
// Overview of operation
// RQ1 - Ten-bit up counter advances on each active edge of the selected clock.
// RQ2 - Period compare holds three bits, compared with counter bits 9 to 7.
// RQ3 - Compare A holds ten bits, compared with the whole counter.
// RQ4 - Software cannot write the counter; an on-bit rise clears it.
// RQ5 - Overflow or selected compare match clears counter and raises interrupt.
// RQ6 - Modes: compare match output, timer/event counter, PWM output.
// RQ7 - Two outputs; the second is the same waveform or its inverse.
// RQ8 - Low bytes go through one shared buffer, moved only on high-byte access.
// RQ9 - Writing compare low byte fills only the buffer.
// RQ10 - Writing compare high byte loads it and copies buffer into low byte.
// RQ11 - Reading a high byte returns it and captures low byte into buffer.
// RQ12 - Reading a low byte address returns the buffer.
// RQ13 - Software writes low then high, reads high then low.
// RQ14 - Counter pair is read only; compare A pair is read/write.
// RQ15 - Counter high byte bits 7..2 read zero, bits 1..0 are counter 9..8.
// RQ16 - Select bit 7 routes third timer clock from port A2 or D2.
// RQ17 - Select bit 6 routes second timer clock from port A0 or D3.
// RQ18 - Select bit 5 routes this timer clock from port A2 or D1.
// RQ19 - Select bits 3..0 pick LCD segment or enhanced timer output on D7..D4.
// RQ20 - Software never enables more than one timer input in capture mode.
// RQ21 - Clear select 0 clears on period match, 1 on compare A match.
// RQ22 - One buffer serves every low-byte access of the timer.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module ctc_timer (
  input  wire logic                       clock_i,
  input  wire logic                       sys_rst_i,
  input  wire logic [ctc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [ctc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       fh_div16_tick_i,
  input  wire logic                       fh_div64_tick_i,
  input  wire logic                       fsub_tick_i,
  input  wire logic                       port_a_pin0_i,
  input  wire logic                       port_a_pin2_i,
  input  wire logic                       port_d_pin1_i,
  input  wire logic                       port_d_pin2_i,
  input  wire logic                       port_d_pin3_i,
  input  wire logic                       out_b_invert_i,
  input  wire logic [3:0]                 lcd_segment_i,
  input  wire logic [3:0]                 enhanced_timer_out_i,
  output logic                            second_timer_clock_in_o,
  output logic                            third_timer_clock_in_o,
  output logic                            ext_interrupt_pin_sel_o,
  output logic [3:0]                      port_d_hi_func_o,
  output logic                            compact_timer_out_a_o,
  output logic                            compact_timer_out_b_o,
  output logic                            int_compare_a_o,
  output logic                            int_compare_p_o,
  output logic                            int_req_o
);

  function automatic logic [7:0] hi_byte(input logic [1:0] v);
    hi_byte = {6'h00, v};
  endfunction : hi_byte

  logic [7:0]            pin_function_select_q;
  ctc_pkg::ctc_ctl0_type ctl0_q;
  ctc_pkg::ctc_ctl1_type ctl1_q;
  logic [9:0]            counter_q;
  logic [9:0]            compare_a_value_q;
  logic [7:0]            byte_buf_q;
  logic                  on_prev_q;
  logic [1:0]            div4_q;
  logic [2:0]            pin_sync_q;
  logic                  pin_filt_q;
  logic                  pin_prev_q;
  logic                  cmp_level_q;

  // AXI slave holding state
  logic                       aw_held_q;
  logic [ctc_pkg::ADDR_W-1:0] aw_addr_q;
  logic                       w_held_q;
  logic [7:0]                 w_data_q;
  logic                       w_lane_q;

  logic       wr_fire;
  logic       rd_fire;
  logic       on_rise;
  logic       src_tick;
  logic       tick;
  logic [9:0] period_last;
  logic       a_hit;
  logic       p_hit;
  logic       ovf_hit;
  logic       clear_hit;
  logic       pwm_active;
  logic       wave;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_lane_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  function automatic logic mapped(input logic [ctc_pkg::ADDR_W-1:0] a);
    mapped = (a == ctc_pkg::OFF_PIN_FUNCTION_SELECT) || (a == ctc_pkg::OFF_TIMER_CONTROL_ZERO)
          || (a == ctc_pkg::OFF_TIMER_CONTROL_ONE) || (a == ctc_pkg::OFF_COUNTER_VALUE_LOW)
          || (a == ctc_pkg::OFF_COUNTER_VALUE_HIGH) || (a == ctc_pkg::OFF_COMPARE_A_LOW)
          || (a == ctc_pkg::OFF_COMPARE_A_HIGH);
  endfunction : mapped

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ctc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_q) ? ctc_pkg::RESP_OKAY : ctc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Low-byte addresses return the buffer, never the live low byte
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ctc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? ctc_pkg::RESP_OKAY : ctc_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        ctc_pkg::OFF_PIN_FUNCTION_SELECT: s_axi_rdata <= {24'h0, pin_function_select_q};
        ctc_pkg::OFF_TIMER_CONTROL_ZERO:  s_axi_rdata <= {24'h0, ctl0_q};
        ctc_pkg::OFF_TIMER_CONTROL_ONE:   s_axi_rdata <= {24'h0, ctl1_q};
        ctc_pkg::OFF_COUNTER_VALUE_LOW:   s_axi_rdata <= {24'h0, byte_buf_q}; // RQ12
        ctc_pkg::OFF_COUNTER_VALUE_HIGH:  s_axi_rdata <= {24'h0, hi_byte(counter_q[9:8])}; // RQ15
        ctc_pkg::OFF_COMPARE_A_LOW:       s_axi_rdata <= {24'h0, byte_buf_q}; // RQ12
        ctc_pkg::OFF_COMPARE_A_HIGH:      s_axi_rdata <= {24'h0, hi_byte(compare_a_value_q[9:8])};
        default:                          s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = wr_fire && w_lane_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pin_function_select_q <= ctc_pkg::RST_PIN_FUNCTION_SELECT;
      ctl0_q                <= ctc_pkg::ctc_ctl0_type'(ctc_pkg::RST_CONTROL);
      ctl1_q                <= ctc_pkg::ctc_ctl1_type'(ctc_pkg::RST_CONTROL);
    end else if (wr_en) begin
      if (aw_addr_q == ctc_pkg::OFF_PIN_FUNCTION_SELECT) pin_function_select_q <= w_data_q;
      if (aw_addr_q == ctc_pkg::OFF_TIMER_CONTROL_ZERO)  ctl0_q <= ctc_pkg::ctc_ctl0_type'(w_data_q);
      if (aw_addr_q == ctc_pkg::OFF_TIMER_CONTROL_ONE)   ctl1_q <= ctc_pkg::ctc_ctl1_type'(w_data_q);
    end
  end

  // One buffer for all pairs, so interleaving two pairs corrupts a transfer
  // Write side wins over a same-cycle high-byte read capture
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      byte_buf_q <= 8'h00;
    end else if (wr_en && aw_addr_q == ctc_pkg::OFF_COMPARE_A_LOW) begin
      byte_buf_q <= w_data_q; // RQ9 RQ22
    end else if (rd_fire && s_axi_araddr == ctc_pkg::OFF_COUNTER_VALUE_HIGH) begin
      byte_buf_q <= counter_q[7:0]; // RQ11 RQ22
    end else if (rd_fire && s_axi_araddr == ctc_pkg::OFF_COMPARE_A_HIGH) begin
      byte_buf_q <= compare_a_value_q[7:0]; // RQ11
    end
  end

  // Counter pair has no write path; compare pair moves only on its high byte
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      compare_a_value_q <= ctc_pkg::RST_COMPARE_A;
    end else if (wr_en && aw_addr_q == ctc_pkg::OFF_COMPARE_A_HIGH) begin
      compare_a_value_q <= {w_data_q[1:0], byte_buf_q}; // RQ8 RQ10 RQ14
    end
  end

  // Pin routing, registered so the outputs come from flip-flops
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      third_timer_clock_in_o  <= 1'b0;
      second_timer_clock_in_o <= 1'b0;
      ext_interrupt_pin_sel_o <= 1'b0;
      port_d_hi_func_o        <= 4'h0;
    end else begin
      third_timer_clock_in_o  <= pin_function_select_q[ctc_pkg::THIRD_TIMER_CLOCK_PIN_SEL]
                                 ? port_d_pin2_i : port_a_pin2_i; // RQ16
      second_timer_clock_in_o <= pin_function_select_q[ctc_pkg::SECOND_TIMER_CLOCK_PIN_SEL]
                                 ? port_d_pin3_i : port_a_pin0_i; // RQ17
      ext_interrupt_pin_sel_o <= pin_function_select_q[ctc_pkg::EXT_INTERRUPT_PIN_SEL];
      for (int i = 0; i < 4; i++) begin
        port_d_hi_func_o[i] <= pin_function_select_q[ctc_pkg::PORTD4_SPECIAL_SEL + i]
                               ? enhanced_timer_out_i[i] : lcd_segment_i[i]; // RQ19
      end
    end
  end

  // External clock pin: three stages, level taken when stages two and three agree
  logic pin_raw;
  assign pin_raw = pin_function_select_q[ctc_pkg::COMPACT_TIMER_CLOCK_PIN_SEL]
                   ? port_d_pin1_i : port_a_pin2_i; // RQ18

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pin_sync_q <= 3'h0;
      pin_filt_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], pin_raw};
      if (pin_sync_q[1] == pin_sync_q[2]) pin_filt_q <= pin_sync_q[2];
      pin_prev_q <= pin_filt_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) div4_q <= 2'h0;
    else           div4_q <= div4_q + 2'h1;
  end

  // Reserved source gives no edges, which halts the counter
  always_comb begin
    unique case (ctl0_q.clk_sel)
      ctc_pkg::CK_SYS_DIV4: src_tick = (div4_q == ctc_pkg::SYS_DIV4_LAST);
      ctc_pkg::CK_SYS:      src_tick = 1'b1;
      ctc_pkg::CK_FH_DIV16: src_tick = fh_div16_tick_i;
      ctc_pkg::CK_FH_DIV64: src_tick = fh_div64_tick_i;
      ctc_pkg::CK_SUB:      src_tick = fsub_tick_i;
      ctc_pkg::CK_RESERVED: src_tick = 1'b0;
      ctc_pkg::CK_PIN_RISE: src_tick = pin_filt_q && !pin_prev_q;
      ctc_pkg::CK_PIN_FALL: src_tick = !pin_filt_q && pin_prev_q;
    endcase
  end

  assign on_rise     = ctl0_q.timer_on_control && !on_prev_q;
  assign tick        = src_tick && ctl0_q.timer_on_control && !ctl0_q.pause && !on_rise; // RQ1
  // Last count before the top three bits reach the period value; zero means full wrap
  assign period_last = {ctl0_q.period_compare_value, 7'h00} - 10'h001; // RQ2
  assign p_hit       = tick && (counter_q == period_last); // RQ2
  assign a_hit       = tick && (counter_q == compare_a_value_q); // RQ3
  assign ovf_hit     = tick && (counter_q == ctc_pkg::COUNTER_MAX);
  assign clear_hit   = ovf_hit || (ctl1_q.counter_clear_select ? a_hit : p_hit); // RQ21

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) on_prev_q <= 1'b0;
    else           on_prev_q <= ctl0_q.timer_on_control;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      counter_q <= ctc_pkg::RST_COUNTER;
    end else if (on_rise) begin
      counter_q <= 10'h000; // RQ4
    end else if (clear_hit) begin
      counter_q <= 10'h000; // RQ5
    end else if (tick) begin
      counter_q <= counter_q + 10'h001; // RQ1
    end
  end

  // Each comparator raises its own request whether or not it clears the counter
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      int_compare_a_o <= 1'b0;
      int_compare_p_o <= 1'b0;
      int_req_o       <= 1'b0;
    end else begin
      int_compare_a_o <= a_hit;
      int_compare_p_o <= p_hit;
      int_req_o       <= a_hit || p_hit || ovf_hit; // RQ5
    end
  end

  // Compare output level: initial level on enable, then steered by A matches
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cmp_level_q <= 1'b0;
    end else if (on_rise) begin
      cmp_level_q <= ctl1_q.out_ctrl;
    end else if (a_hit && ctl1_q.mode == ctc_pkg::MODE_COMPARE) begin
      unique case (ctl1_q.out_func)
        2'b00: cmp_level_q <= cmp_level_q;
        2'b01: cmp_level_q <= 1'b0;
        2'b10: cmp_level_q <= 1'b1;
        2'b11: cmp_level_q <= !cmp_level_q; // RQ6
      endcase
    end
  end

  // PWM duty from A and period from P, or swapped
  assign pwm_active = ctl1_q.duty_swap ? (counter_q < {ctl0_q.period_compare_value, 7'h00})
                                       : (counter_q < compare_a_value_q);

  always_comb begin
    unique case (ctl1_q.mode)
      ctc_pkg::MODE_COMPARE: wave = cmp_level_q;
      ctc_pkg::MODE_PWM: begin
        unique case (ctl1_q.out_func)
          2'b00:   wave = !ctl1_q.out_ctrl;
          2'b01:   wave = ctl1_q.out_ctrl;
          2'b10:   wave = pwm_active ? ctl1_q.out_ctrl : !ctl1_q.out_ctrl; // RQ6
          default: wave = !ctl1_q.out_ctrl;
        endcase
      end
      default: wave = 1'b0;
    endcase
  end

  // Timer/counter mode leaves the pins low; polarity then has no effect
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      compact_timer_out_a_o <= 1'b0;
      compact_timer_out_b_o <= 1'b0;
    end else if (ctl1_q.mode == ctc_pkg::MODE_TIMER || ctl1_q.mode == ctc_pkg::MODE_UNDEF) begin
      compact_timer_out_a_o <= 1'b0;
      compact_timer_out_b_o <= 1'b0;
    end else begin
      compact_timer_out_a_o <= wave ^ ctl1_q.polarity; // RQ6
      compact_timer_out_b_o <= wave ^ ctl1_q.polarity ^ out_b_invert_i; // RQ7
    end
  end

  sequence s_hi_read(logic [ctc_pkg::ADDR_W-1:0] a);
    rd_fire && s_axi_araddr == a && !wr_en;
  endsequence

  sequence s_lo_read;
    rd_fire && (s_axi_araddr == ctc_pkg::OFF_COUNTER_VALUE_LOW
             || s_axi_araddr == ctc_pkg::OFF_COMPARE_A_LOW);
  endsequence

  property p_on_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
      $rose(ctl0_q.timer_on_control) |=> counter_q == 10'h000;
  endproperty
  a_on_clear: assert property (p_on_clear) else $error("Counter not cleared on enable"); // RQ4

  property p_count_up;
    @(posedge clock_i) disable iff (sys_rst_i)
      tick && !clear_hit |=> counter_q == $past(counter_q) + 10'h001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("Counter failed to advance"); // RQ1

  property p_no_count_paused;
    @(posedge clock_i) disable iff (sys_rst_i)
      ctl0_q.pause && !on_rise |=> $stable(counter_q);
  endproperty
  a_no_count_paused: assert property (p_no_count_paused) else $error("Counted while paused"); // RQ1

  property p_period_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
      tick && !ctl1_q.counter_clear_select && counter_q == period_last
      |=> counter_q == 10'h000 ##0 int_req_o;
  endproperty
  a_period_clear: assert property (p_period_clear) else $error("Period match missed"); // RQ2

  property p_a_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
      tick && ctl1_q.counter_clear_select && counter_q == compare_a_value_q
      |=> counter_q == 10'h000 && int_compare_a_o;
  endproperty
  a_a_clear: assert property (p_a_clear) else $error("Compare A match missed"); // RQ3

  property p_irq_on_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
      clear_hit |=> int_req_o ##1 !int_req_o || clear_hit;
  endproperty
  a_irq_on_clear: assert property (p_irq_on_clear) else $error("No request on clear"); // RQ5

  property p_low_write_buffers;
    @(posedge clock_i) disable iff (sys_rst_i)
      wr_en && aw_addr_q == ctc_pkg::OFF_COMPARE_A_LOW
      |=> $stable(compare_a_value_q) && byte_buf_q == $past(w_data_q);
  endproperty
  a_low_write_buffers: assert property (p_low_write_buffers) else $error("Low write leaked"); // RQ9

  property p_high_write_copies;
    @(posedge clock_i) disable iff (sys_rst_i)
      wr_en && aw_addr_q == ctc_pkg::OFF_COMPARE_A_HIGH
      |=> compare_a_value_q == {$past(w_data_q[1:0]), $past(byte_buf_q)};
  endproperty
  a_high_write_copies: assert property (p_high_write_copies) else $error("High write bad"); // RQ10

  property p_high_read_captures;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_hi_read(ctc_pkg::OFF_COUNTER_VALUE_HIGH)
      |=> byte_buf_q == $past(counter_q[7:0]) && s_axi_rdata[7:2] == 6'h00
          && s_axi_rdata[1:0] == $past(counter_q[9:8]);
  endproperty
  a_high_read_captures: assert property (p_high_read_captures) else $error("High read bad"); // RQ11

  property p_low_read_buffer;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_lo_read |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(byte_buf_q)};
  endproperty
  a_low_read_buffer: assert property (p_low_read_buffer) else $error("Low read not buffer"); // RQ12

  property p_third_clock_route;
    @(posedge clock_i) disable iff (sys_rst_i)
      pin_function_select_q[ctc_pkg::THIRD_TIMER_CLOCK_PIN_SEL]
      |=> third_timer_clock_in_o == $past(port_d_pin2_i);
  endproperty
  a_third_clock_route: assert property (p_third_clock_route) else $error("Routing wrong"); // RQ16

endmodule : ctc_timer

// ### dv/ctc_timer_tb_top.sv
// Testbench for the compact timer core, driven over its register bus
`timescale 1ns/1ns
module ctc_timer_tb_top;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [4:0]  awaddr = 5'h00;
  logic [4:0]  araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        sec_clk, thr_clk, ext_sel, out_a, out_b, hit_a, hit_p, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, hi, lo, h2, l2;
  logic [4:0]  pins = 5'h00; // pd3 pd2 pd1 pa2 pa0
  logic [3:0]  pd_func;
  logic [3:0]  lcd = 4'h5;
  logic [3:0]  enh = 4'ha;
  logic [7:0]  sel;
  logic        inv = 1'b0;
  int          failures = 0;
  int          comparisons = 0;
  int          gap;
  ctc_timer i_ctc_timer (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fh_div16_tick_i(1'b0), .fh_div64_tick_i(1'b0), .fsub_tick_i(1'b0),
    .port_a_pin0_i(pins[0]), .port_a_pin2_i(pins[1]), .port_d_pin1_i(pins[2]),
    .port_d_pin2_i(pins[3]), .port_d_pin3_i(pins[4]), .out_b_invert_i(inv),
    .lcd_segment_i(lcd), .enhanced_timer_out_i(enh), .second_timer_clock_in_o(sec_clk),
    .third_timer_clock_in_o(thr_clk), .ext_interrupt_pin_sel_o(ext_sel),
    .port_d_hi_func_o(pd_func), .compact_timer_out_a_o(out_a), .compact_timer_out_b_o(out_b),
    .int_compare_a_o(hit_a), .int_compare_p_o(hit_p), .int_req_o(irq));
  always #25 clock_i = ~clock_i;
  task conclude;
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task hang;
    failures++;
    $display("unexpected at %0t: no answer in time", $time);
    conclude();
  endtask : hang
  // Channels are released one by one as taken; the answer is awaited, never assumed
  task wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 20) hang();
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [4:0] a, output logic [31:0] d);
    int n;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 20) hang();
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  // Edges between two successive hits of the chosen comparator
  task period(input logic use_p, output int c);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge clock_i);
      if ((use_p ? hit_p : hit_a) === 1'b1) break;
    end
    for (c = 1; c < 2000; c++) begin
      @(posedge clock_i);
      if ((use_p ? hit_p : hit_a) === 1'b1) break;
    end
    if (n == 2000 || c == 2000) hang();
    chk(irq, 1'b1);
  endtask : period
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), hi);
      chk(hi, 32'h0);
      chk(32'(resp), (i == 7) ? 32'(ctc_pkg::RESP_SLVERR) : 32'(ctc_pkg::RESP_OKAY));
    end
    wr(5'h1c, 8'h01);
    chk(32'(resp), 32'(ctc_pkg::RESP_SLVERR));
    for (int i = 0; i < 2; i++) begin
      sel = i ? 8'hb5 : 8'h4a;
      pins <= i ? 5'h07 : 5'h18;
      wr(5'h00, sel);
      repeat (2) @(posedge clock_i);
      chk(thr_clk, sel[7] ? pins[3] : pins[1]);
      chk(sec_clk, sel[6] ? pins[4] : pins[0]);
      chk(ext_sel, sel[4]);
      chk(pd_func, (enh & sel[3:0]) | (lcd & ~sel[3:0]));
      rd(5'h00, hi);
      chk(hi, {24'h0, sel});
    end
    wr(5'h14, 8'ha5);
    rd(5'h18, hi);
    rd(5'h14, lo);
    chk(lo, 32'h0);
    wr(5'h14, 8'ha5);
    wr(5'h18, 8'h01);
    rd(5'h18, hi);
    chk(hi, 32'h1);
    rd(5'h14, lo);
    chk(lo, 32'ha5);
    // An interleaved counter read overwrites the pending compare low byte
    wr(5'h14, 8'h5a);
    rd(5'h10, hi);
    wr(5'h18, 8'h01);
    rd(5'h18, hi);
    rd(5'h14, lo);
    chk(lo, 32'h0);
    wr(5'h14, 8'ha5);
    wr(5'h18, 8'h01);
    wr(5'h08, 8'h01);
    wr(5'h04, 8'h18);
    period(1'b0, gap);
    chk(gap, 32'h1a6);
    wr(5'h04, 8'h98);
    rd(5'h10, hi);
    rd(5'h0c, lo);
    rd(5'h10, h2);
    rd(5'h0c, l2);
    chk(hi & 32'hfffffffc, 32'h0);
    chk({h2, l2}, {hi, lo});
    inv <= 1'b1;
    wr(5'h08, 8'h00);
    wr(5'h04, 8'h19);
    period(1'b1, gap);
    chk(gap, 32'h80);
    wr(5'h04, 8'h50);
    wr(5'h04, 8'h58);
    wr(5'h0c, 8'hff);
    wr(5'h10, 8'h03);
    rd(5'h10, hi);
    rd(5'h0c, lo);
    chk({hi[7:0], lo[7:0]}, 32'h0);
    // PWM held in its active state, active high; the second pin runs inverted
    wr(5'h08, 8'h98);
    repeat (2) @(posedge clock_i);
    chk(out_a, 1'b1);
    chk(out_b, 1'b0);
    // Three filtered rises on port D pin 1, the only clock input selected
    wr(5'h00, 8'h20);
    wr(5'h04, 8'h68);
    for (int k = 0; k < 6; k++) begin
      pins[2] <= k[0];
      repeat (6) @(posedge clock_i);
    end
    rd(5'h10, hi);
    rd(5'h0c, lo);
    chk({hi[1:0], lo[7:0]}, 32'h3);
    conclude();
  end
endmodule : ctc_timer_tb_top
